/* bench/idt_core_decode_monitor.sv */
`timescale 1ns/10ps
module idt_core_decode_monitor
    import idt_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic [13:0] PM_WORD,
    input wire logic FETCH_STB,
    input wire logic [1:0] Q_PHASE,
    input wire logic [1:0] INSTR_CLASS,
    input wire logic [6:0] FILE_ADDR,
    input wire logic [2:0] BIT_SEL,
    input wire logic DEST_FILE,
    input wire logic PTR_NUM,
    input wire logic [1:0] PTR_MODE,
    input wire logic [1:0] CYCLE_COUNT,
    input wire logic FR_RD_STB,
    input wire logic FR_WR_STB
);
    logic [3:0] gap_q;
    logic [3:0] gap_d;
    logic [13:0] word_q;
    logic [13:0] word_d;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    // Clocks since the last fetch and the word taken there
    always_comb begin
        gap_d = FETCH_STB ? 4'h1 : gap_q + 4'h1;
        word_d = FETCH_STB ? PM_WORD : word_q;
        if (!RST_N) begin
            gap_d = 4'h1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        gap_q <= gap_d;
        word_q <= word_d;
    end

    ////////////////////////////////////////
    sequence s_rest_of_cycle;
        Q_PHASE == 2'h1 ##1 Q_PHASE == 2'h2 ##1 Q_PHASE == IDT_LAST_PHASE;
    endsequence
    sequence s_read_slot;
        Q_PHASE == IDT_READ_PHASE ##1 (!FR_RD_STB && !FR_WR_STB);
    endsequence

    property p_phase_walk;
        Q_PHASE == 2'h0 |=> s_rest_of_cycle ##1 Q_PHASE == 2'h0;
    endproperty
    a_phase_walk: assert property (p_phase_walk)
        else $error("phase sequence broken");
    property p_fetch_phase;
        FETCH_STB |-> Q_PHASE == IDT_LAST_PHASE;
    endproperty
    a_fetch_phase: assert property (p_fetch_phase)
        else $error("fetch outside last phase");
    property p_fetch_gap;
        FETCH_STB |-> gap_q == {CYCLE_COUNT, 2'b00};
    endproperty
    a_fetch_gap: assert property (p_fetch_gap)
        else $error("fetch spacing wrong");
    property p_gap_bound;
        gap_q <= 4'hc;
    endproperty
    a_gap_bound: assert property (p_gap_bound)
        else $error("instruction longer than three cycles");
    property p_fields;
        FETCH_STB |=> FILE_ADDR == word_q[6:0] && BIT_SEL == word_q[9:7] && DEST_FILE == word_q[7];
    endproperty
    a_fields: assert property (p_fields)
        else $error("operand fields wrong");
    property p_pointer;
        FETCH_STB |=> PTR_NUM == word_q[2] && PTR_MODE == word_q[1:0];
    endproperty
    a_pointer: assert property (p_pointer)
        else $error("pointer fields wrong");
    property p_class_bit;
        FETCH_STB && PM_WORD[13:12] == 2'h1 |=> INSTR_CLASS == IDT_CLS_BIT;
    endproperty
    a_class_bit: assert property (p_class_bit)
        else $error("bit class wrong");
    property p_read_slot;
        FR_RD_STB |-> s_read_slot;
    endproperty
    a_read_slot: assert property (p_read_slot)
        else $error("read strobe misplaced");
    property p_rmw;
        FR_WR_STB |-> $past(FR_RD_STB, 2) && Q_PHASE == IDT_LAST_PHASE;
    endproperty
    a_rmw: assert property (p_rmw)
        else $error("write without read first");
    property p_dest;
        FR_RD_STB && INSTR_CLASS == IDT_CLS_BYTE |-> ##2 FR_WR_STB == DEST_FILE;
    endproperty
    a_dest: assert property (p_dest)
        else $error("destination select wrong");
endmodule : idt_core_decode_monitor

bind idt_core_decode idt_core_decode_monitor idt_core_decode_monitor_i (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .PM_WORD(PM_WORD), .FETCH_STB(FETCH_STB),
    .Q_PHASE(Q_PHASE), .INSTR_CLASS(INSTR_CLASS), .FILE_ADDR(FILE_ADDR), .BIT_SEL(BIT_SEL),
    .DEST_FILE(DEST_FILE), .PTR_NUM(PTR_NUM), .PTR_MODE(PTR_MODE),
    .CYCLE_COUNT(CYCLE_COUNT), .FR_RD_STB(FR_RD_STB), .FR_WR_STB(FR_WR_STB));

/* bench/idt_file_mem.sv */
`timescale 1ns/10ps
module idt_file_mem
    import idt_pkg::*;
(
    input wire logic clk,
    input wire logic rd_stb,
    input wire logic wr_stb,
    input wire logic [6:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:127];
    logic [7:0] held_q = 8'h00;
    logic valid_q = 1'b0;

    // Read answered in the next clock, write taken on its strobe
    always @(posedge clk) begin
        valid_q <= rd_stb;
        if (rd_stb) held_q <= mem[addr];
        if (wr_stb) mem[addr] <= wdata;
    end

    // Outside its valid clock the bus shows the inverse of the last data
    assign rdata = valid_q ? held_q : ~held_q;
endmodule : idt_file_mem

/* bench/test_cpu_instruction_decode_timing.sv */
`timescale 1ns/10ps
module test_cpu_instruction_decode_timing
    import idt_pkg::*;
;
    logic CLK_SYS, RST_N, FETCH_STB, DEST_FILE, PTR_NUM, FR_RD_STB, FR_WR_STB, SKIP_NEXT;
    logic [13:0] PM_WORD;
    logic [1:0] IND_PTR_IN_PM, Q_PHASE, INSTR_CLASS, PTR_MODE, CYCLE_COUNT;
    logic [6:0] FILE_ADDR;
    logic [2:0] BIT_SEL;
    logic [7:0] FR_RDATA, FR_WDATA, W_REG;
    logic [4:0] STATUS_FLAGS, m_flg;
    int num_errors, n_tests, m_w, seed;
    int m_mem [128];
    bit chk_data;
    // Directed program: pointer-in-memory bits above the word
    localparam logic [15:0] PROG [32] = '{
        16'h3085, 16'h00a0, 16'h01a1, 16'h0720, 16'h3ef6, 16'h0aa0, 16'h17a1, 16'h10a0,
        16'h0821, 16'h017f, 16'h0060, 16'h2005, 16'h2805, 16'h0008, 16'h0009, 16'h000a,
        16'h000b, 16'h3412, 16'h3210, 16'h1c20, 16'h1820, 16'h0ba0, 16'h0fa1, 16'h4800,
        16'h8800, 16'h8881, 16'h4012, 16'h8016, 16'h0011, 16'h0013, 16'h0063, 16'h0064};

    idt_core_decode idt_core_decode_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PM_WORD(PM_WORD),
        .FETCH_STB(FETCH_STB), .IND_PTR_IN_PM(IND_PTR_IN_PM), .Q_PHASE(Q_PHASE),
        .INSTR_CLASS(INSTR_CLASS), .FILE_ADDR(FILE_ADDR), .BIT_SEL(BIT_SEL),
        .DEST_FILE(DEST_FILE), .PTR_NUM(PTR_NUM), .PTR_MODE(PTR_MODE),
        .CYCLE_COUNT(CYCLE_COUNT), .FR_RD_STB(FR_RD_STB), .FR_RDATA(FR_RDATA),
        .FR_WR_STB(FR_WR_STB), .FR_WDATA(FR_WDATA), .W_REG(W_REG),
        .STATUS_FLAGS(STATUS_FLAGS), .SKIP_NEXT(SKIP_NEXT));
    idt_file_mem idt_file_mem_i (.clk(CLK_SYS), .rd_stb(FR_RD_STB), .wr_stb(FR_WR_STB),
        .addr(FILE_ADDR), .wdata(FR_WDATA), .rdata(FR_RDATA));

    ////////////////////////////////////////
    task automatic stop_test();
        if (num_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
            num_errors++;
        end
    endtask : check

    // One instruction: feed at fetch, watch strobes, then model it
    task automatic run(input logic [15:0] ent);
        logic [13:0] word;
        logic [1:0] pm;
        logic [7:0] wdat;
        logic has_f, ind, wr, sk;
        int n, rd_n, wr_n, cyc, a, r;
        word = ent[13:0];
        pm = ent[15:14];
        n = 0;
        while (FETCH_STB !== 1'b1 && n < 20) begin
            @(negedge CLK_SYS);
            n++;
        end
        if (n >= 20) begin
            num_errors++;
            stop_test();
        end
        PM_WORD = word;
        IND_PTR_IN_PM = pm;
        has_f = !word[13] && word[13:7] != 7'h00 && word[13:7] != 7'h02;
        ind = has_f && word[6:1] == 6'h0 ? pm[word[0]] : word[13:4] == 10'h001 && pm[word[2]];
        wr = has_f && ((word[13:12] == 2'h0 && word[7]) || word[13:11] == 3'b010);
        cyc = 1 + ind;
        if (word[13:12] == 2'h2 || word inside {[14'h0008:14'h000b]} || word[13:10] == 4'hd
            || word[13:9] == 5'h19 || word[13:11] == 3'b011
            || (word[13:12] == 2'h0 && word[11:8] inside {4'hb, 4'hf})) cyc++;
        n = 0;
        rd_n = 0;
        wr_n = 0;
        do begin
            @(negedge CLK_SYS);
            n++;
            if (n == 1) begin
                PM_WORD = ~word;
                check(FILE_ADDR, word[6:0]);
                check({BIT_SEL, DEST_FILE}, {word[9:7], word[7]});
                check({PTR_NUM, PTR_MODE}, {word[2], word[1:0]});
                check(CYCLE_COUNT, cyc);
                if (word[13] || has_f) check(INSTR_CLASS, word[13] ? IDT_CLS_LITCTL :
                    (word[12] ? IDT_CLS_BIT : IDT_CLS_BYTE));
            end
            if (FR_RD_STB === 1'b1) rd_n = n;
            if (FR_WR_STB === 1'b1) begin
                wr_n = n;
                wdat = FR_WDATA;
            end
        end while (FETCH_STB !== 1'b1 && n < 16);
        check(n, 4 * cyc);
        check(rd_n * 16 + wr_n, (has_f ? 32 : 0) + (wr ? 4 : 0));
        a = word[13] ? int'(word[7:0]) : m_mem[word[6:0]];
        r = -1;
        sk = (word[13:11] == 3'b011) ? (a[word[9:7]] == word[10]) : 1'b0;
        case (word[13:8]) inside
            6'h07, 6'h3e, 6'h3f: begin
                r = a + m_w;
                m_flg[1] = (a % 16 + m_w % 16) > 15;
                m_flg[0] = r > 255;
            end
            6'h08, 6'h30, [6'h34:6'h37]: r = a;
            6'h0a, 6'h0f: r = a + 1;
            6'h0b: r = a + 255;
            6'h00: if (word[7]) r = m_w;
            6'h01: r = 0;
            [6'h10:6'h13]: r = a & ~(1 << word[9:7]);
            [6'h14:6'h17]: r = a | (1 << word[9:7]);
            default: ;
        endcase
        if (r >= 0) begin
            r = r % 256;
            if (word[13:8] inside {6'h0b, 6'h0f}) sk = (r == 0);
            if (word[13:8] inside {6'h07, 6'h08, 6'h0a, 6'h01, 6'h3e, 6'h3f}) m_flg[2] = r == 0;
            if (wr && chk_data) check(wdat, r);
            if (wr) m_mem[word[6:0]] = r;
            else m_w = r;
        end
        if (word == IDT_SLEEP_WORD) m_flg[4:3] = 2'b10;
        if (word == IDT_CLRWDT_WORD) m_flg[4:3] = 2'b11;
        if (chk_data) check({W_REG, 3'h0, STATUS_FLAGS}, {m_w[7:0], 3'h0, m_flg});
        if (chk_data) check(SKIP_NEXT, sk);
    endtask : run

    function automatic logic [15:0] rnd_word();
        logic [3:0] lit [9] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha, 4'hc, 4'he};
        logic [13:0] w;
        w = {2'h3, lit[$urandom % 9], 8'($urandom)};
        case ($urandom % 4)
            0: w = {2'h0, 4'(2 + $urandom % 14), 8'($urandom)};
            1: w = {2'h1, 12'($urandom)};
            2: w[13:12] = 2'h2;
            default: ;
        endcase
        if ($urandom % 3 == 0) w[6:1] = 6'h0;
        return {2'($urandom), w};
    endfunction : rnd_word

    ////////////////////////////////////////
    // Free-running oscillator
    initial begin
        CLK_SYS = 1'b0;
        forever #10 CLK_SYS = ~CLK_SYS;
    end

    // Reset, directed program, random timing, second reset
    initial begin
        RST_N = 1'b0;
        PM_WORD = IDT_NOP_WORD;
        IND_PTR_IN_PM = 2'h0;
        num_errors = 0;
        n_tests = 0;
        chk_data = 1'b1;
        m_w = 0;
        m_flg = IDT_FLAGS_RST;
        seed = $urandom(32'h32e1);
        for (int i = 0; i < 128; i++) begin
            m_mem[i] = $urandom % 256;
            idt_file_mem_i.mem[i] = 8'(m_mem[i]);
        end
        repeat (2) @(negedge CLK_SYS);
        check({W_REG, STATUS_FLAGS}, {8'h00, IDT_FLAGS_RST});
        RST_N = 1'b1;
        foreach (PROG[i]) run(PROG[i]);
        chk_data = 1'b0;
        repeat (200) run(rnd_word());
        RST_N = 1'b0;
        repeat (2) @(negedge CLK_SYS);
        check({W_REG, STATUS_FLAGS, CYCLE_COUNT}, {8'h00, IDT_FLAGS_RST, IDT_CYC_ONE});
        RST_N = 1'b1;
        chk_data = 1'b1;
        m_w = 0;
        m_flg = IDT_FLAGS_RST;
        run(16'h3fff);
        stop_test();
    end
endmodule : test_cpu_instruction_decode_timing

/* hw/idt_core_decode.sv */
`timescale 1ns/10ps
module idt_core_decode
    import idt_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic [13:0] PM_WORD,
    output logic FETCH_STB,
    input wire logic [1:0] IND_PTR_IN_PM,
    output logic [1:0] Q_PHASE,
    output logic [1:0] INSTR_CLASS,
    output logic [6:0] FILE_ADDR,
    output logic [2:0] BIT_SEL,
    output logic DEST_FILE,
    output logic PTR_NUM,
    output logic [1:0] PTR_MODE,
    output logic [1:0] CYCLE_COUNT,
    output logic FR_RD_STB,
    input wire logic [7:0] FR_RDATA,
    output logic FR_WR_STB,
    output logic [7:0] FR_WDATA,
    output logic [7:0] W_REG,
    output logic [4:0] STATUS_FLAGS,
    output logic SKIP_NEXT
);

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer state
    logic [1:0] phase_q, phase_d;
    logic [1:0] remain_q, remain_d;
    idt_state_t state_q, state_d;
    logic [13:0] instr_q, instr_d;
    idt_class_t cls_q, cls_d;
    logic [6:0] faddr_q, faddr_d;
    logic [2:0] bsel_q, bsel_d;
    logic dest_q, dest_d;
    logic ptr_q, ptr_d;
    logic [1:0] pmode_q, pmode_d;
    logic [1:0] cycles_q, cycles_d;
    logic names_file_q, names_file_d;
    logic last_edge;

    ////////////////////////////////////////////////////////////////////////////////
    // Datapath state
    logic [7:0] w_q, w_d;
    logic [4:0] flags_q, flags_d;
    logic [7:0] res_q, res_d;
    logic wr_q, wr_d;
    logic skip_q, skip_d;

    // Word taken at the last clock of the last cycle
    assign last_edge = (phase_q == IDT_LAST_PHASE) && (remain_q == IDT_CYC_ONE);
    assign FETCH_STB = last_edge;

    // Next sequencer values and decode of the incoming word
    always_comb begin
        logic indirect;
        logic ind_sel;
        indirect = 1'b0;
        ind_sel = 1'b0;
        phase_d = phase_q + 2'h1;
        remain_d = remain_q;
        state_d = state_q;
        instr_d = instr_q;
        cls_d = cls_q;
        faddr_d = faddr_q;
        bsel_d = bsel_q;
        dest_d = dest_q;
        ptr_d = ptr_q;
        pmode_d = pmode_q;
        cycles_d = cycles_q;
        names_file_d = names_file_q;
        if (last_edge) begin
            instr_d = PM_WORD;
            faddr_d = PM_WORD[6:0];
            bsel_d = PM_WORD[9:7];
            dest_d = PM_WORD[7];
            ptr_d = PM_WORD[2];
            pmode_d = PM_WORD[1:0];
            cycles_d = IDT_CYC_ONE;
            names_file_d = 1'b0;
            // Class from the top two opcode bits
            case (PM_WORD[13:12])
                2'h0: begin
                    cls_d = IDT_CLS_BYTE;
                end
                2'h1: begin
                    cls_d = IDT_CLS_BIT;
                end
                default: begin
                    cls_d = IDT_CLS_LITCTL;
                end
            endcase
            // File operand exists for bit words, and for byte words unless bit 7 is zero and the opcode field is 0 or 1
            if (PM_WORD[13:12] == 2'h1) begin
                names_file_d = 1'b1;
            end else if (PM_WORD[13:12] == 2'h0) begin
                names_file_d = (PM_WORD[11:8] != 4'h0) || PM_WORD[7];
            end
            // Control words; x bits are wildcards
            casez (PM_WORD)
                14'b10_????_????_????: begin
                    cycles_d = IDT_CYC_TWO;
                end
                14'b00_0000_0000_1010: begin
                    cycles_d = IDT_CYC_TWO;
                end
                14'b00_0000_0000_1000, 14'b00_0000_0000_1001, 14'b11_01??_????_????: begin
                    cycles_d = IDT_CYC_TWO;
                end
                14'b11_001?_????_????, 14'b00_0000_0000_1011: begin
                    cycles_d = IDT_CYC_TWO;
                end
                14'b01_1???_????_????, 14'b00_1011_????_????, 14'b00_1111_????_????: begin
                    cycles_d = IDT_CYC_TWO;
                end
                14'b00_0000_0001_????: begin
                    indirect = 1'b1;
                    ind_sel = PM_WORD[2];
                end
                14'b00_0001_0???_????: begin
                    names_file_d = 1'b0;
                end
                default: begin
                    cycles_d = IDT_CYC_ONE;
                end
            endcase
            // Indirect register named as the file operand
            if (names_file_d && (PM_WORD[6:0] == IDT_IND0_ADDR || PM_WORD[6:0] == IDT_IND1_ADDR)) begin
                indirect = 1'b1;
                ind_sel = (PM_WORD[6:0] == IDT_IND1_ADDR);
            end
            if (indirect && IND_PTR_IN_PM[ind_sel]) begin
                cycles_d = cycles_d + 2'h1;
            end
            remain_d = cycles_d;
            state_d = IDT_ST_EXEC;
        end else if (phase_q == IDT_LAST_PHASE) begin
            remain_d = remain_q - 2'h1;
            state_d = IDT_ST_WAIT;
        end
    end

    // Sequencer registers
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            phase_q <= 2'h0;
            remain_q <= IDT_CYC_ONE;
            state_q <= IDT_ST_WAIT;
            instr_q <= IDT_NOP_WORD;
            cls_q <= IDT_CLS_BYTE;
            faddr_q <= 7'h00;
            bsel_q <= 3'h0;
            dest_q <= 1'b0;
            ptr_q <= 1'b0;
            pmode_q <= 2'h0;
            cycles_q <= IDT_CYC_ONE;
            names_file_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            remain_q <= remain_d;
            state_q <= state_d;
            instr_q <= instr_d;
            cls_q <= cls_d;
            faddr_q <= faddr_d;
            bsel_q <= bsel_d;
            dest_q <= dest_d;
            ptr_q <= ptr_d;
            pmode_q <= pmode_d;
            cycles_q <= cycles_d;
            names_file_q <= names_file_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read in the second clock, write back in the fourth
    assign FR_RD_STB = (state_q == IDT_ST_EXEC) && (phase_q == IDT_READ_PHASE) && names_file_q;
    assign FR_WR_STB = (state_q == IDT_ST_EXEC) && (phase_q == IDT_LAST_PHASE) && wr_q;

    // Next datapath values, computed in the third clock
    always_comb begin
        logic [7:0] opnd;
        logic [7:0] res;
        logic [8:0] sum;
        logic [4:0] nib;
        logic to_file;
        logic upd_z;
        logic upd_arith;
        opnd = names_file_q ? FR_RDATA : instr_q[7:0];
        res = opnd;
        sum = 9'h000;
        nib = 5'h00;
        to_file = 1'b0;
        upd_z = 1'b0;
        upd_arith = 1'b0;
        w_d = w_q;
        flags_d = flags_q;
        res_d = res_q;
        wr_d = wr_q;
        skip_d = skip_q;
        if ((state_q == IDT_ST_EXEC) && (phase_q == IDT_ALU_PHASE)) begin
            skip_d = 1'b0;
            case (cls_q)
                IDT_CLS_BYTE: begin
                    to_file = dest_q;
                    case (instr_q[11:8])
                        4'h0: begin
                            res = w_q;
                            to_file = dest_q;
                        end
                        4'h1: begin
                            res = 8'h00;
                            upd_z = 1'b1;
                        end
                        4'h2: begin
                            sum = {1'b0, opnd} + {1'b0, ~w_q} + 9'h001;
                            nib = {1'b0, opnd[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01;
                            res = sum[7:0];
                            upd_arith = 1'b1;
                        end
                        4'h3, 4'hb: begin
                            res = opnd - 8'h01;
                            upd_z = (instr_q[11:8] == 4'h3);
                            skip_d = (instr_q[11:8] == 4'hb) && (res == 8'h00);
                        end
                        4'h4: begin
                            res = opnd | w_q;
                            upd_z = 1'b1;
                        end
                        4'h5: begin
                            res = opnd & w_q;
                            upd_z = 1'b1;
                        end
                        4'h6: begin
                            res = opnd ^ w_q;
                            upd_z = 1'b1;
                        end
                        4'h7: begin
                            sum = {1'b0, opnd} + {1'b0, w_q};
                            nib = {1'b0, opnd[3:0]} + {1'b0, w_q[3:0]};
                            res = sum[7:0];
                            upd_arith = 1'b1;
                        end
                        4'h8: begin
                            res = opnd;
                            upd_z = 1'b1;
                        end
                        4'h9: begin
                            res = ~opnd;
                            upd_z = 1'b1;
                        end
                        4'ha, 4'hf: begin
                            res = opnd + 8'h01;
                            upd_z = (instr_q[11:8] == 4'ha);
                            skip_d = (instr_q[11:8] == 4'hf) && (res == 8'h00);
                        end
                        4'hc: begin
                            res = {flags_q[IDT_FLG_C], opnd[7:1]};
                            flags_d[IDT_FLG_C] = opnd[0];
                        end
                        4'hd: begin
                            res = {opnd[6:0], flags_q[IDT_FLG_C]};
                            flags_d[IDT_FLG_C] = opnd[7];
                        end
                        default: begin
                            res = {opnd[3:0], opnd[7:4]};
                        end
                    endcase
                    if (instr_q == IDT_SLEEP_WORD) begin
                        flags_d[IDT_FLG_TO] = 1'b1;
                        flags_d[IDT_FLG_PD] = 1'b0;
                    end else if (instr_q == IDT_CLRWDT_WORD) begin
                        flags_d[IDT_FLG_TO] = 1'b1;
                        flags_d[IDT_FLG_PD] = 1'b1;
                    end
                end
                IDT_CLS_BIT: begin
                    res = opnd;
                    to_file = !instr_q[11];
                    if (!instr_q[11]) begin
                        res[bsel_q] = instr_q[10];
                    end else begin
                        skip_d = (opnd[bsel_q] == instr_q[10]);
                    end
                end
                default: begin
                    to_file = 1'b0;
                    casez (instr_q[13:8])
                        6'b11_111?: begin
                            sum = {1'b0, opnd} + {1'b0, w_q};
                            nib = {1'b0, opnd[3:0]} + {1'b0, w_q[3:0]};
                            res = sum[7:0];
                            upd_arith = 1'b1;
                        end
                        6'b11_110?: begin
                            sum = {1'b0, opnd} + {1'b0, ~w_q} + 9'h001;
                            nib = {1'b0, opnd[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01;
                            res = sum[7:0];
                            upd_arith = 1'b1;
                        end
                        6'b11_1001: begin
                            res = opnd & w_q;
                            upd_z = 1'b1;
                        end
                        6'b11_1000: begin
                            res = opnd | w_q;
                            upd_z = 1'b1;
                        end
                        6'b11_1010: begin
                            res = opnd ^ w_q;
                            upd_z = 1'b1;
                        end
                        // Relative branch falls to default and leaves W alone
                        6'b11_0000, 6'b11_01??: begin
                            res = opnd;
                        end
                        default: begin
                            res = w_q;
                        end
                    endcase
                end
            endcase
            if (upd_arith) begin
                flags_d[IDT_FLG_C] = sum[8];
                flags_d[IDT_FLG_DC] = nib[4];
            end
            if (upd_z || upd_arith) begin
                flags_d[IDT_FLG_Z] = (res == 8'h00);
            end
            res_d = res;
            wr_d = names_file_q && to_file;
            if (!to_file || (cls_q == IDT_CLS_BYTE && instr_q[11:8] == 4'h0 && !dest_q)) begin
                w_d = (cls_q == IDT_CLS_BIT) ? w_q : res;
            end
        end
    end

    // Datapath registers
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            w_q <= 8'h00;
            flags_q <= IDT_FLAGS_RST;
            res_q <= 8'h00;
            wr_q <= 1'b0;
            skip_q <= 1'b0;
        end else begin
            w_q <= w_d;
            flags_q <= flags_d;
            res_q <= res_d;
            wr_q <= wr_d;
            skip_q <= skip_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs
    assign Q_PHASE = phase_q;
    assign INSTR_CLASS = cls_q;
    assign FILE_ADDR = faddr_q;
    assign BIT_SEL = bsel_q;
    assign DEST_FILE = dest_q;
    assign PTR_NUM = ptr_q;
    assign PTR_MODE = pmode_q;
    assign CYCLE_COUNT = cycles_q;
    assign FR_WDATA = res_q;
    assign W_REG = w_q;
    assign STATUS_FLAGS = flags_q;
    assign SKIP_NEXT = skip_q;

endmodule : idt_core_decode

/* hw/idt_pkg.sv */
// Behaviour
// - Each instruction is one 14-bit word holding opcode and all operands.
// - Opcodes sort into byte-oriented, bit-oriented and literal/control classes.
// - Every instruction takes one cycle unless listed as longer below.
// - Direct call and call through the accumulator take two cycles.
// - Return, return with literal and return from interrupt take two cycles.
// - Jumps, relative and accumulator branches, and all skip instructions take two cycles.
// - Indirect access through a pointer aimed at program memory adds one cycle.
// - One instruction cycle is exactly four oscillator clocks.
// - Any file register operand is read first; it is written back only when the result goes to the file register.
// - Destination bit 0 stores to the accumulator, 1 to the file register.
// - The file operand is a 7-bit address from 0x00 to 0x7f.
// - The bit operand picks one of eight bits of the addressed register.
// - The pointer-number operand picks indirect pair 0 or 1.
// - A two-bit mode picks pre/post increment or decrement of the pointer.
// - Don't-care instruction bits never change execution.
package idt_pkg;

    localparam int IDT_WORD_W = 14;
    localparam int IDT_FADDR_W = 7;
    localparam int IDT_DATA_W = 8;

    // Oscillator clocks in one instruction cycle
    localparam logic [1:0] IDT_LAST_PHASE = 2'h3;
    localparam logic [1:0] IDT_READ_PHASE = 2'h1;
    localparam logic [1:0] IDT_ALU_PHASE = 2'h2;

    // Instruction cycle counts
    localparam logic [1:0] IDT_CYC_ONE = 2'h1;
    localparam logic [1:0] IDT_CYC_TWO = 2'h2;

    // Indirect access register addresses in the file space
    localparam logic [6:0] IDT_IND0_ADDR = 7'h00;
    localparam logic [6:0] IDT_IND1_ADDR = 7'h01;

    // Status flag bit positions and reset value
    localparam int IDT_FLG_C = 0;
    localparam int IDT_FLG_DC = 1;
    localparam int IDT_FLG_Z = 2;
    localparam int IDT_FLG_PD = 3;
    localparam int IDT_FLG_TO = 4;
    localparam logic [4:0] IDT_FLAGS_RST = 5'h18;

    // Word after reset: no operation
    localparam logic [13:0] IDT_NOP_WORD = 14'h0000;
    localparam logic [13:0] IDT_SLEEP_WORD = 14'h0063;
    localparam logic [13:0] IDT_CLRWDT_WORD = 14'h0064;

    typedef enum logic [1:0] {
        IDT_CLS_BYTE,
        IDT_CLS_BIT,
        IDT_CLS_LITCTL
    } idt_class_t;

    typedef enum logic [1:0] {
        IDT_PM_PRE_INC,
        IDT_PM_PRE_DEC,
        IDT_PM_POST_INC,
        IDT_PM_POST_DEC
    } idt_ptr_mode_t;

    typedef enum logic {
        IDT_ST_EXEC,
        IDT_ST_WAIT
    } idt_state_t;

endpackage : idt_pkg
